//--- include/output_routing_volume_regs.svh
// register offsets, field positions, reset values and timing counts of the output path
`ifndef OUTPUT_ROUTING_VOLUME_REGS_SVH
`define OUTPUT_ROUTING_VOLUME_REGS_SVH

// ***********************************************************
// register offsets
// ***********************************************************
`define OFS_ROUTING 8'h23
`define OFS_LEFT_HP_VOL 8'h24
`define OFS_RIGHT_HP_VOL 8'h25
`define OFS_LEFT_SPK_VOL 8'h26
`define OFS_RIGHT_SPK_VOL 8'h27
`define OFS_LEFT_HP_CTRL 8'h28
`define OFS_RIGHT_HP_CTRL 8'h29

// ***********************************************************
// field positions
// ***********************************************************
`define RT_DAC_LEFT_HI 7
`define RT_DAC_LEFT_LO 6
`define RT_MIC_LEFT_TO_LMIX 5
`define RT_MIC_RIGHT_TO_LMIX 4
`define RT_DAC_RIGHT_HI 3
`define RT_DAC_RIGHT_LO 2
`define RT_MIC_RIGHT_TO_RMIX 1
`define RT_HP_BRIDGE 0
`define VOL_ROUTE_BIT 7
`define VOL_FIELD_HI 6
`define HP_GAIN_HI 6
`define HP_GAIN_LO 3
`define HP_UNMUTE_BIT 2
`define HP_APPLIED_BIT 0

// ***********************************************************
// reset values and limits
// ***********************************************************
`define RST_ROUTING 8'h00
`define RST_VOLUME 8'h7f
`define RST_HP_CTRL 8'h02
`define VOL_MUTE_CODE 7'h7f
`define HP_GAIN_MAX 4'h9
`define HP_CTRL_WR_MASK 8'hfe

// ***********************************************************
// timing
// ***********************************************************
`define CLK_PERIOD_NS 8
`define GAIN_STEP_TIME_NS 1000
`define GAIN_STEP_CYCLES ((`GAIN_STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- include/output_routing_volume_pkg.sv
// types shared by the output routing and volume register block
package output_routing_volume_pkg;

   typedef enum logic [1:0] {
      ROUTE_OFF = 2'b00,
      ROUTE_MIXER = 2'b01,
      ROUTE_DIRECT_HP = 2'b10,
      ROUTE_RESERVED = 2'b11
   } route_e;

   typedef enum logic {
      SETTLED = 1'b0,
      RAMPING = 1'b1
   } settle_e;

endpackage : output_routing_volume_pkg

//--- verilog/gain_settle.sv
// steps an applied analog setting toward its programmed target
`timescale 1ns/1ps
`default_nettype none

module gain_settle
   import output_routing_volume_pkg::*;
#(
   parameter int WIDTH = 7,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [WIDTH-1:0] target,
   input wire logic stepTick,
   output logic [WIDTH-1:0] current,
   output logic applied
);

   settle_e state_ff;
   logic [WIDTH-1:0] target_ff;
   logic [WIDTH-1:0] current_ff;

   // ***********************************************************
   // target capture and one step per tick
   // ***********************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         target_ff <= RESET_VALUE;
      end else if (load) begin
         target_ff <= target;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         current_ff <= RESET_VALUE;
      end else if (stepTick && !load && (current_ff != target_ff)) begin
         if (current_ff < target_ff) begin
            current_ff <= current_ff + {{(WIDTH-1){1'b0}}, 1'b1};
         end else begin
            current_ff <= current_ff - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // a load in the tick cycle keeps the stage pending: the new write wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= RAMPING;
      end else begin
         case (state_ff)
            SETTLED: begin
               if (load) begin
                  state_ff <= RAMPING;
               end
            end
            RAMPING: begin
               if (!load && stepTick && (current_ff == target_ff)) begin
                  state_ff <= SETTLED;
               end
            end
            default: begin
               state_ff <= RAMPING;
            end
         endcase
      end
   end

   assign current = current_ff;
   assign applied = (state_ff == SETTLED);

endmodule : gain_settle

`default_nettype wire

//--- verilog/output_routing_volume_regs.sv
// output routing, analog volume and headphone driver control registers
//
// What this block does
// - routing bits 7:6 steer left converter: off, left mixer, left headphone driver
// - routing bits 3:2 steer right converter: off, right mixer, right headphone driver
// - routing bit 5 connects left positive mic input to left mixer
// - routing bit 4 connects right positive mic input to left mixer
// - routing bit 1 connects right positive mic input to right mixer
// - routing bit 0 feeds left headphone driver into right one, differential
// - left-to-left-headphone volume: 7-bit attenuation, reset all ones, mute on 0/7f
// - right-to-right-headphone volume: same attenuation, reset and mute behaviour
// - left-to-left-speaker volume: same attenuation, reset and mute behaviour
// - right-to-right-speaker volume: same attenuation, reset and mute behaviour
// - left headphone gain bits 6:3, 0..9 dB; codes 10..15 stored but applied as 9
// - right headphone gain bits 6:3, 0..9 dB; codes 10..15 stored but applied as 9
// - left headphone driver bit 2: zero mutes (reset), one unmutes
// - right headphone driver bit 2: zero mutes (reset), one unmutes
// - left headphone bit 0 read-only: one once all programmed gains applied
// - right headphone bit 0 read-only: one once all programmed gains applied
`timescale 1ns/1ps
`default_nettype none
`include "output_routing_volume_regs.svh"

module output_routing_volume_regs
   import output_routing_volume_pkg::*;
#(
   parameter int STEP_CYCLES = `GAIN_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic dacLeftToLeftMixer,
   output logic dacLeftToLeftHp,
   output logic micLeftPosToLeftMixer,
   output logic micRightPosToLeftMixer,
   output logic dacRightToRightMixer,
   output logic dacRightToRightHp,
   output logic micRightPosToRightMixer,
   output logic leftHpToRightHp,
   output logic [6:0] leftHpVolume,
   output logic leftHpVolumeMute,
   output logic [6:0] rightHpVolume,
   output logic rightHpVolumeMute,
   output logic [6:0] leftSpkVolume,
   output logic leftSpkVolumeMute,
   output logic [6:0] rightSpkVolume,
   output logic rightSpkVolumeMute,
   output logic [3:0] leftHpGain,
   output logic leftHpUnmute,
   output logic [3:0] rightHpGain,
   output logic rightHpUnmute,
   output logic leftHpGainsApplied,
   output logic rightHpGainsApplied
);

   // ***********************************************************
   // helpers
   // ***********************************************************
   function automatic logic wrHit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
      return en && (a == ofs);
   endfunction : wrHit

   // path is silent only with the route bit low and full attenuation
   function automatic logic volMuted(input logic [7:0] v);
      return !v[`VOL_ROUTE_BIT] && (v[`VOL_FIELD_HI:0] == `VOL_MUTE_CODE);
   endfunction : volMuted

   // out-of-range codes are held at the top step so the stage never leaves range
   function automatic logic [3:0] gainClamp(input logic [7:0] c);
      logic [3:0] g;
      g = c[`HP_GAIN_HI:`HP_GAIN_LO];
      return (g > `HP_GAIN_MAX) ? `HP_GAIN_MAX : g;
   endfunction : gainClamp

   // ***********************************************************
   // registers
   // ***********************************************************
   logic [7:0] routing_ff;
   logic [7:0] leftHpVol_ff;
   logic [7:0] rightHpVol_ff;
   logic [7:0] leftSpkVol_ff;
   logic [7:0] rightSpkVol_ff;
   logic [7:0] leftHpCtrl_ff;
   logic [7:0] rightHpCtrl_ff;
   logic wrRouting;
   logic wrLeftHpVol;
   logic wrRightHpVol;
   logic wrLeftHpCtrl;
   logic wrRightHpCtrl;

   assign wrRouting = wrHit(regWrEn, regAddr, `OFS_ROUTING);
   assign wrLeftHpVol = wrHit(regWrEn, regAddr, `OFS_LEFT_HP_VOL);
   assign wrRightHpVol = wrHit(regWrEn, regAddr, `OFS_RIGHT_HP_VOL);
   assign wrLeftHpCtrl = wrHit(regWrEn, regAddr, `OFS_LEFT_HP_CTRL);
   assign wrRightHpCtrl = wrHit(regWrEn, regAddr, `OFS_RIGHT_HP_CTRL);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         routing_ff <= `RST_ROUTING;
      end else if (wrRouting) begin
         routing_ff <= regWrData;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         leftHpVol_ff <= `RST_VOLUME;
         rightHpVol_ff <= `RST_VOLUME;
         leftSpkVol_ff <= `RST_VOLUME;
         rightSpkVol_ff <= `RST_VOLUME;
      end else begin
         if (wrLeftHpVol) begin
            leftHpVol_ff <= regWrData;
         end
         if (wrRightHpVol) begin
            rightHpVol_ff <= regWrData;
         end
         if (wrHit(regWrEn, regAddr, `OFS_LEFT_SPK_VOL)) begin
            leftSpkVol_ff <= regWrData;
         end
         if (wrHit(regWrEn, regAddr, `OFS_RIGHT_SPK_VOL)) begin
            rightSpkVol_ff <= regWrData;
         end
      end
   end

   // bit 0 is never stored; it always shows the settle flag
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         leftHpCtrl_ff <= `RST_HP_CTRL;
         rightHpCtrl_ff <= `RST_HP_CTRL;
      end else begin
         if (wrLeftHpCtrl) begin
            leftHpCtrl_ff <= regWrData & `HP_CTRL_WR_MASK;
         end
         if (wrRightHpCtrl) begin
            rightHpCtrl_ff <= regWrData & `HP_CTRL_WR_MASK;
         end
      end
   end

   // ***********************************************************
   // routing decode
   // ***********************************************************
   route_e leftRoute;
   route_e rightRoute;

   // reserved code 11 leaves the converter unconnected rather than double-driving
   assign leftRoute = route_e'(routing_ff[`RT_DAC_LEFT_HI:`RT_DAC_LEFT_LO]);
   assign rightRoute = route_e'(routing_ff[`RT_DAC_RIGHT_HI:`RT_DAC_RIGHT_LO]);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dacLeftToLeftMixer <= 1'b0;
         dacLeftToLeftHp <= 1'b0;
         dacRightToRightMixer <= 1'b0;
         dacRightToRightHp <= 1'b0;
      end else begin
         dacLeftToLeftMixer <= (leftRoute == ROUTE_MIXER);
         dacLeftToLeftHp <= (leftRoute == ROUTE_DIRECT_HP);
         dacRightToRightMixer <= (rightRoute == ROUTE_MIXER);
         dacRightToRightHp <= (rightRoute == ROUTE_DIRECT_HP);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         micLeftPosToLeftMixer <= 1'b0;
         micRightPosToLeftMixer <= 1'b0;
         micRightPosToRightMixer <= 1'b0;
         leftHpToRightHp <= 1'b0;
      end else begin
         micLeftPosToLeftMixer <= routing_ff[`RT_MIC_LEFT_TO_LMIX];
         micRightPosToLeftMixer <= routing_ff[`RT_MIC_RIGHT_TO_LMIX];
         micRightPosToRightMixer <= routing_ff[`RT_MIC_RIGHT_TO_RMIX];
         leftHpToRightHp <= routing_ff[`RT_HP_BRIDGE];
      end
   end

   // ***********************************************************
   // volume and driver controls
   // ***********************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         leftHpVolumeMute <= 1'b1;
         rightHpVolumeMute <= 1'b1;
         leftSpkVolumeMute <= 1'b1;
         rightSpkVolumeMute <= 1'b1;
         leftSpkVolume <= `VOL_MUTE_CODE;
         rightSpkVolume <= `VOL_MUTE_CODE;
         leftHpUnmute <= 1'b0;
         rightHpUnmute <= 1'b0;
      end else begin
         leftHpVolumeMute <= volMuted(leftHpVol_ff);
         rightHpVolumeMute <= volMuted(rightHpVol_ff);
         leftSpkVolumeMute <= volMuted(leftSpkVol_ff);
         rightSpkVolumeMute <= volMuted(rightSpkVol_ff);
         leftSpkVolume <= leftSpkVol_ff[`VOL_FIELD_HI:0];
         rightSpkVolume <= rightSpkVol_ff[`VOL_FIELD_HI:0];
         leftHpUnmute <= leftHpCtrl_ff[`HP_UNMUTE_BIT];
         rightHpUnmute <= rightHpCtrl_ff[`HP_UNMUTE_BIT];
      end
   end

   // ***********************************************************
   // step divider and settle trackers
   // ***********************************************************
   localparam int CW = $clog2(STEP_CYCLES + 1);
   logic [CW-1:0] stepCnt_ff;
   logic stepTick;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stepCnt_ff <= '0;
      end else if (stepTick) begin
         stepCnt_ff <= '0;
      end else begin
         stepCnt_ff <= stepCnt_ff + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   assign stepTick = (stepCnt_ff == CW'(STEP_CYCLES - 1));

   logic leftVolDone;
   logic rightVolDone;
   logic leftGainDone;
   logic rightGainDone;

   gain_settle #(.WIDTH(7), .RESET_VALUE(`VOL_MUTE_CODE)) leftVolSettle (
      .clk(clk),
      .nrst(nrst),
      .load(wrLeftHpVol),
      .target(regWrData[`VOL_FIELD_HI:0]),
      .stepTick(stepTick),
      .current(leftHpVolume),
      .applied(leftVolDone)
   );

   gain_settle #(.WIDTH(7), .RESET_VALUE(`VOL_MUTE_CODE)) rightVolSettle (
      .clk(clk),
      .nrst(nrst),
      .load(wrRightHpVol),
      .target(regWrData[`VOL_FIELD_HI:0]),
      .stepTick(stepTick),
      .current(rightHpVolume),
      .applied(rightVolDone)
   );

   gain_settle #(.WIDTH(4), .RESET_VALUE(4'h0)) leftGainSettle (
      .clk(clk),
      .nrst(nrst),
      .load(wrLeftHpCtrl),
      .target(gainClamp(regWrData)),
      .stepTick(stepTick),
      .current(leftHpGain),
      .applied(leftGainDone)
   );

   gain_settle #(.WIDTH(4), .RESET_VALUE(4'h0)) rightGainSettle (
      .clk(clk),
      .nrst(nrst),
      .load(wrRightHpCtrl),
      .target(gainClamp(regWrData)),
      .stepTick(stepTick),
      .current(rightHpGain),
      .applied(rightGainDone)
   );

   assign leftHpGainsApplied = leftVolDone && leftGainDone;
   assign rightHpGainsApplied = rightVolDone && rightGainDone;

   // ***********************************************************
   // read port
   // ***********************************************************
   logic [7:0] rdMux;

   always_comb begin
      case (regAddr)
         `OFS_ROUTING: rdMux = routing_ff;
         `OFS_LEFT_HP_VOL: rdMux = leftHpVol_ff;
         `OFS_RIGHT_HP_VOL: rdMux = rightHpVol_ff;
         `OFS_LEFT_SPK_VOL: rdMux = leftSpkVol_ff;
         `OFS_RIGHT_SPK_VOL: rdMux = rightSpkVol_ff;
         `OFS_LEFT_HP_CTRL: rdMux = {leftHpCtrl_ff[7:1], leftHpGainsApplied};
         `OFS_RIGHT_HP_CTRL: rdMux = {rightHpCtrl_ff[7:1], rightHpGainsApplied};
         default: rdMux = 8'h00;
      endcase
   end

   // reserved bits 7 and 1 are stored as written; software owns their values
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         regRdData <= rdMux;
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_left_dac_route: assert property (
      wrRouting && (regWrData[7:6] == 2'b10) |-> ##2 dacLeftToLeftHp && !dacLeftToLeftMixer)
      else $error("left converter not routed to headphone driver");

   a_right_dac_route: assert property (
      wrRouting && (regWrData[3:2] == 2'b01) |-> ##2 dacRightToRightMixer && !dacRightToRightHp)
      else $error("right converter not routed to right mixer");

   a_reserved_route_off: assert property (
      routing_ff[7:6] == 2'b11 |=> !dacLeftToLeftMixer && !dacLeftToLeftHp)
      else $error("reserved left route drives a path");

   a_mic_left_mix: assert property (
      wrRouting |-> ##2 (micLeftPosToLeftMixer == $past(regWrData[5], 2)))
      else $error("left mic to left mixer mismatch");

   a_mic_right_lmix: assert property (
      wrRouting |-> ##2 (micRightPosToLeftMixer == $past(regWrData[4], 2)))
      else $error("right mic to left mixer mismatch");

   a_mic_right_rmix: assert property (
      wrRouting |-> ##2 (micRightPosToRightMixer == $past(regWrData[1], 2)))
      else $error("right mic to right mixer mismatch");

   a_hp_bridge: assert property (
      wrRouting |-> ##2 (leftHpToRightHp == $past(regWrData[0], 2)))
      else $error("headphone bridge mismatch");

   a_left_hp_mute: assert property (
      wrLeftHpVol && (regWrData == 8'h7f) |-> ##2 leftHpVolumeMute)
      else $error("left headphone volume not muted");

   a_right_hp_mute: assert property (
      wrRightHpVol && (regWrData == 8'hff) |-> ##2 !rightHpVolumeMute)
      else $error("right headphone volume muted with route bit set");

   a_left_spk_mute: assert property (
      ##1 (leftSpkVolumeMute == (($past(leftSpkVol_ff) & 8'hff) == 8'h7f)))
      else $error("left speaker mute wrong");

   a_right_spk_mute: assert property (
      ##1 (rightSpkVolumeMute == ($past(rightSpkVol_ff) == 8'h7f)))
      else $error("right speaker mute wrong");

   a_gain_range: assert property (
      (leftHpGain <= 4'h9) && (rightHpGain <= 4'h9))
      else $error("headphone gain out of range");

   a_right_unmute: assert property (
      wrRightHpCtrl |-> ##2 (rightHpUnmute == $past(regWrData[2], 2)))
      else $error("right headphone mute mismatch");

   a_left_unmute: assert property (
      wrLeftHpCtrl |-> ##2 (leftHpUnmute == $past(regWrData[2], 2)))
      else $error("left headphone mute mismatch");

   a_flag_readback: assert property (
      regRdEn && (regAddr == 8'h28) |=> (regRdData[0] == $past(leftHpGainsApplied)))
      else $error("left applied flag readback wrong");

   a_write_clears: assert property (
      wrLeftHpVol || wrLeftHpCtrl |=> !leftHpGainsApplied)
      else $error("left applied flag not cleared by write");

   a_right_clears: assert property (
      wrRightHpVol || wrRightHpCtrl |=> !rightHpGainsApplied)
      else $error("right applied flag not cleared by write");

endmodule : output_routing_volume_regs

`default_nettype wire

//--- verif/output_routing_volume_regs_tb.sv
// self-checking bench for the output routing and volume register block
`timescale 1ns/1ps
`default_nettype none

module output_routing_volume_regs_tb;
   import output_routing_volume_pkg::*;
   // ***********************************************************
   // signals and model
   // ***********************************************************
   localparam int STEP = 4; // short step so headphone ramps stay brief
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic dLM, dLH, mLL, mRL, dRM, dRH, mRR, bridge;
   logic [6:0] lhv, rhv, lsv, rsv;
   logic lhm, rhm, lsm, rsm, lu, ru, lAp, rAp;
   logic [3:0] lg, rg;
   int err_total = 0;
   int n_tests = 0;
   logic [7:0] mdl [35:41];
   logic [7:0] rdv;
   logic [7:0] d;
   int k;

   always #4 clk = ~clk;

   output_routing_volume_regs #(.STEP_CYCLES(STEP)) output_routing_volume_regs_inst (
      .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regWrData(regWrData), .regRdData(regRdData), .dacLeftToLeftMixer(dLM),
      .dacLeftToLeftHp(dLH), .micLeftPosToLeftMixer(mLL), .micRightPosToLeftMixer(mRL),
      .dacRightToRightMixer(dRM), .dacRightToRightHp(dRH), .micRightPosToRightMixer(mRR),
      .leftHpToRightHp(bridge), .leftHpVolume(lhv), .leftHpVolumeMute(lhm),
      .rightHpVolume(rhv), .rightHpVolumeMute(rhm), .leftSpkVolume(lsv),
      .leftSpkVolumeMute(lsm), .rightSpkVolume(rsv), .rightSpkVolumeMute(rsm),
      .leftHpGain(lg), .leftHpUnmute(lu), .rightHpGain(rg), .rightHpUnmute(ru),
      .leftHpGainsApplied(lAp), .rightHpGainsApplied(rAp)
   );

   // ***********************************************************
   // tasks
   // ***********************************************************
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // called at a falling edge, returns at a falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      regAddr = a;
      regWrData = v;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
      if (a >= 8'h23 && a <= 8'h29) mdl[a] = v;
      // idle cycle keeps back-to-back strobes apart
      @(negedge clk);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      rdv = regRdData;
      chk("read", rdv, e);
      @(negedge clk);
   endtask : rd_chk

   // readback once settled: flag bit reads one, never the written bit 0
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      if (a == 8'h28 || a == 8'h29) return {mdl[a][7:1], 1'b1};
      return mdl[a];
   endfunction : exp_rd

   task automatic chk_route();
      chk("route", {dLM, dLH, mLL, mRL, dRM, dRH, mRR, bridge},
          {mdl[35][7:6] == 2'b01, mdl[35][7:6] == 2'b10, mdl[35][5:4],
           mdl[35][3:2] == 2'b01, mdl[35][3:2] == 2'b10, mdl[35][1:0]});
   endtask : chk_route

   task automatic wait_settle(output int n);
      for (n = 0; n < 3000 && !(lAp === 1'b1 && rAp === 1'b1); n++) @(negedge clk);
      chk("settle", 8'(n < 3000), 8'h01);
   endtask : wait_settle

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // ***********************************************************
   // watchdog
   // ***********************************************************
   initial begin
      #400000;
      err_total++;
      give_verdict();
   end

   // ***********************************************************
   // tests
   // ***********************************************************
   initial begin
      void'($urandom(32'h400d));
      mdl[35] = 8'h00;
      for (int i = 36; i <= 39; i++) mdl[i] = 8'h7f;
      mdl[40] = 8'h02;
      mdl[41] = 8'h02;
      repeat (2) @(negedge clk);
      chk("reset route", {dLM, dLH, mLL, mRL, dRM, dRH, mRR, bridge}, 8'h00);
      chk("reset flags", {lAp, rAp, lu, ru, lhm, rhm, lsm, rsm}, 8'h0f);
      chk("reset gain", {lg, rg}, 8'h00);
      chk("reset vol", {1'b0, lhv}, 8'h7f);
      nrst = 1'b1;
      wait_settle(k);
      wr(8'h2a, 8'hff);
      for (int a = 35; a <= 41; a++) rd_chk(8'(a), exp_rd(8'(a)));
      rd_chk(8'h2a, 8'h00);
      rd_chk(8'h22, 8'h00);
      $display("test reset done");

      // every route code for both converters, reserved included, random mic and bridge bits
      for (int i = 0; i < 16; i++) begin
         d = {2'(i % 4), 2'($urandom), 2'(i / 4), 2'($urandom)};
         wr(8'h23, d);
         @(negedge clk);
         chk_route();
         rd_chk(8'h23, d);
      end
      $display("test routing done");

      // mute only for bit 7 low with an all-ones field
      for (int a = 36; a <= 39; a++) begin
         for (int j = 0; j < 5; j++) begin
            d = (j == 0) ? 8'h7f : (j == 1) ? 8'hff : (j == 2) ? 8'h7e : 8'($urandom);
            wr(8'(a), d);
            @(negedge clk);
            chk("vol mute", {lhm, rhm, lsm, rsm}, {mdl[36] == 8'h7f, mdl[37] == 8'h7f,
                mdl[38] == 8'h7f, mdl[39] == 8'h7f});
            chk("spk vol", {1'b0, lsv}, {1'b0, mdl[38][6:0]});
            chk("spk vol", {1'b0, rsv}, {1'b0, mdl[39][6:0]});
         end
      end
      wait_settle(k);
      chk("hp vol", {1'b0, lhv}, {1'b0, mdl[36][6:0]});
      chk("hp vol", {1'b0, rhv}, {1'b0, mdl[37][6:0]});
      for (int a = 36; a <= 39; a++) rd_chk(8'(a), mdl[a]);
      $display("test volume done");

      // a far volume move clears only the left flag
      wr(8'h24, mdl[36] ^ 8'h40);
      repeat (3) @(negedge clk);
      chk("vol pending", {lAp, rAp}, 8'h01);
      wait_settle(k);

      // gain 0 to 9 takes nine steps; a written bit 0 must not stick
      wr(8'h28, 8'h4f);
      repeat (3) @(negedge clk);
      chk("gain pending", {lAp, rAp}, 8'h01);
      wait_settle(k);
      chk("ramp time", 8'((k + 4) > 9 * STEP && (k + 4) <= 10 * STEP), 8'h01);
      chk("gain", {lg, lu, 3'b000}, {4'h9, 1'b1, 3'b000});
      rd_chk(8'h28, 8'h4f);
      for (int i = 0; i < 8; i++) begin
         d = {1'b0, 4'($urandom % 10), 1'($urandom), 2'b10};
         wr(8'(40 + i % 2), d);
         wait_settle(k);
         chk("hp gain", {lg, rg}, {mdl[40][6:3], mdl[41][6:3]});
         chk("hp unmute", {lu, ru}, {mdl[40][2], mdl[41][2]});
         rd_chk(8'(40 + i % 2), exp_rd(8'(40 + i % 2)));
      end
      chk("route kept", {dLM, dLH, mLL, mRL, dRM, dRH, mRR, bridge},
          {mdl[35][7:6] == 2'b01, mdl[35][7:6] == 2'b10, mdl[35][5:4],
           mdl[35][3:2] == 2'b01, mdl[35][3:2] == 2'b10, mdl[35][1:0]});
      $display("test driver done");
      give_verdict();
   end
endmodule : output_routing_volume_regs_tb

`default_nettype wire
